// >>> tdm_pkg.sv
// What this block does
// - A channel's drive fault flag rises once 128 bit periods pass with no bipolar pulse seen on its line output.
// - The drive fault flag is low whenever a bipolar pulse was seen within the last 128 bit periods.
// - The monitor takes activity from the external monitor inputs or from an internal tap of the line output, per the selected source.
// - In hardware mode a high edge select makes all transmitters sample the rail inputs on the rising transmit clock edge.
// - In hardware mode a low edge select makes all transmitters sample the rail inputs on the falling transmit clock edge.
// - In host mode the edge select input stops selecting edges and serves as the serial port clock.
// - A positive mark drives the positive line output above the negative one for the pulse.
// - A negative mark drives the positive line output below the negative one for the pulse.
// - Both line outputs of a channel are tri-stated while its transmitter-on control is 0.
// - Internal monitoring may be chosen only in host mode; hardware mode always uses the external inputs.
package tdm_pkg;

  // Sizes
  localparam int NUM_CH   = 3;
  localparam int MON_BITS = 128;
  localparam int CNT_W    = 8;
  localparam int ADDR_W   = 4;
  localparam int DATA_W   = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_MASK   = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_FAULT  = 4'hc;

  // Control field positions and reset values
  localparam int CTRL_TXON_LSB = 0;
  localparam int CTRL_INTMON   = 3;
  localparam int CTRL_RISE     = 4;
  localparam int CTRL_W        = 5;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
  localparam logic [NUM_CH-1:0] CH_ZERO  = 3'h0;

  // One channel's rail pair
  typedef struct packed {
    logic pos;
    logic neg;
  } tdm_rail_s;

  // One channel's line driver
  typedef struct packed {
    logic pos;
    logic neg;
    logic oe;
  } tdm_line_s;

  // All pin inputs that cross into the clock domain
  typedef struct packed {
    logic              host;
    logic              edge_sel;
    logic [NUM_CH-1:0] txon;
    logic [NUM_CH-1:0] tclk;
    logic [NUM_CH-1:0] pos;
    logic [NUM_CH-1:0] neg;
    logic [NUM_CH-1:0] mpos;
    logic [NUM_CH-1:0] mneg;
  } tdm_pins_s;

  localparam tdm_pins_s PINS_RST = '0;

endpackage : tdm_pkg

// >>> tdm_chan.sv
`timescale 1ns/1ps
module tdm_chan #(
  parameter int THRESH = tdm_pkg::MON_BITS,
  parameter int CNT_W  = tdm_pkg::CNT_W
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic                ce,
  // Bit timing and data
  input  wire logic                strobe,
  input  wire tdm_pkg::tdm_rail_s  rail,
  input  wire tdm_pkg::tdm_rail_s  mon,
  // Control
  input  wire logic                use_int,
  input  wire logic                drv_on,
  // Results
  output tdm_pkg::tdm_line_s       line,
  output logic                     fault
);

  localparam logic [CNT_W-1:0] THR = CNT_W'(THRESH);
  localparam logic [CNT_W-1:0] ONE = CNT_W'(1);

  tdm_pkg::tdm_line_s line_ff, nxt_line;
  logic [CNT_W-1:0]   cnt_ff, nxt_cnt;
  logic               act_ff, nxt_act;
  logic               fault_ff, nxt_fault;
  logic               cur_act;
  logic               act_any;

  // Line drive, activity capture and idle counter
  always_comb begin
    if (use_int) begin
      cur_act = line_ff.oe & (line_ff.pos | line_ff.neg);
    end else begin
      cur_act = mon.pos ^ mon.neg;
    end
    act_any   = act_ff | cur_act;
    nxt_line  = line_ff;
    nxt_cnt   = cnt_ff;
    nxt_act   = act_any;
    if (strobe) begin
      nxt_line.pos = rail.pos & ~rail.neg;
      nxt_line.neg = rail.neg & ~rail.pos;
      nxt_act      = 1'b0;
      if (act_any) begin
        nxt_cnt = '0;
      end else if (cnt_ff < THR) begin
        nxt_cnt = cnt_ff + ONE;
      end
    end
    nxt_line.oe = drv_on;
    if (!drv_on) begin
      nxt_line.pos = 1'b0;
      nxt_line.neg = 1'b0;
    end
    nxt_fault = (nxt_cnt >= THR);
  end

  // State registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      line_ff  <= '0;
      cnt_ff   <= '0;
      act_ff   <= 1'b0;
      fault_ff <= 1'b0;
    end else if (ce) begin
      line_ff  <= nxt_line;
      cnt_ff   <= nxt_cnt;
      act_ff   <= nxt_act;
      fault_ff <= nxt_fault;
    end
  end

  assign line  = line_ff;
  assign fault = fault_ff;

  // Checks
  property p_fault_hi;
    @(posedge clk) disable iff (!reset_n)
    (ce && strobe && !act_any && cnt_ff == THR - ONE) |=> fault_ff;
  endproperty
  a_fault_hi: assert property (p_fault_hi) else $error("fault missed");

  property p_fault_lo;
    @(posedge clk) disable iff (!reset_n)
    (ce && strobe && act_any) |=> !fault_ff;
  endproperty
  a_fault_lo: assert property (p_fault_lo) else $error("fault held");

  property p_cnt_clr;
    @(posedge clk) disable iff (!reset_n)
    (ce && strobe && act_any) |=> (cnt_ff == '0);
  endproperty
  a_cnt_clr: assert property (p_cnt_clr) else $error("count kept");

  property p_int_tap;
    @(posedge clk) disable iff (!reset_n)
    (ce && use_int && line_ff.oe && line_ff.pos && strobe) |=> !fault_ff;
  endproperty
  a_int_tap: assert property (p_int_tap) else $error("tap ignored");

  property p_mark_pos;
    @(posedge clk) disable iff (!reset_n)
    (ce && strobe && drv_on && rail.pos && !rail.neg)
      |=> (line_ff.pos && !line_ff.neg);
  endproperty
  a_mark_pos: assert property (p_mark_pos) else $error("bad pos mark");

  property p_mark_neg;
    @(posedge clk) disable iff (!reset_n)
    (ce && strobe && drv_on && rail.neg && !rail.pos)
      |=> (line_ff.neg && !line_ff.pos);
  endproperty
  a_mark_neg: assert property (p_mark_neg) else $error("bad neg mark");

  property p_tri;
    @(posedge clk) disable iff (!reset_n)
    (ce && !drv_on) |=> (!line_ff.oe && !line_ff.pos && !line_ff.neg);
  endproperty
  a_tri: assert property (p_tri) else $error("driver not off");

  c_fault: cover property (@(posedge clk) disable iff (!reset_n)
    !fault_ff ##1 fault_ff);
  c_recover: cover property (@(posedge clk) disable iff (!reset_n)
    fault_ff ##1 !fault_ff);

endmodule : tdm_chan

// >>> tdm_top.sv
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module tdm_top #(
  parameter int NUM_CH = tdm_pkg::NUM_CH,
  parameter int THRESH = tdm_pkg::MON_BITS
) (
  // Clock, reset, enable
  input  wire logic                        clk,
  input  wire logic                        reset_n,
  input  wire logic                        ce,
  // Mode and shared edge select pins
  input  wire logic                        host_mode,
  input  wire logic                        tx_clock_edge_select,
  // Terminal side pins
  input  wire logic [NUM_CH-1:0]           tx_line_clock,
  input  wire logic [NUM_CH-1:0]           tx_pos_rail,
  input  wire logic [NUM_CH-1:0]           tx_neg_rail,
  input  wire logic [NUM_CH-1:0]           tx_driver_on,
  // Monitor pins
  input  wire logic [NUM_CH-1:0]           monitor_pos_in,
  input  wire logic [NUM_CH-1:0]           monitor_neg_in,
  // Line outputs
  output logic      [NUM_CH-1:0]           line_out_pos,
  output logic      [NUM_CH-1:0]           line_out_neg,
  output logic      [NUM_CH-1:0]           line_out_oe,
  output logic      [NUM_CH-1:0]           drive_fault_flag,
  // Serial port clock
  output logic                             serial_port_clk,
  // Register port
  input  wire logic [tdm_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [tdm_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [tdm_pkg::DATA_W-1:0]  reg_rdata,
  // Interrupt
  output logic                             irq
);

  tdm_pkg::tdm_pins_s pins_raw;
  tdm_pkg::tdm_pins_s s1_ff, s2_ff, s3_ff, filt_ff, nxt_filt;

  // Pin bundle
  always_comb begin
    pins_raw          = tdm_pkg::PINS_RST;
    pins_raw.host     = host_mode;
    pins_raw.edge_sel = tx_clock_edge_select;
    pins_raw.txon     = tx_driver_on;
    pins_raw.tclk     = tx_line_clock;
    pins_raw.pos      = tx_pos_rail;
    pins_raw.neg      = tx_neg_rail;
    pins_raw.mpos     = monitor_pos_in;
    pins_raw.mneg     = monitor_neg_in;
  end

  // Per bit, accept a change once stages two and three agree
  always_comb begin
    nxt_filt = filt_ff;
    for (int b = 0; b < $bits(tdm_pkg::tdm_pins_s); b++) begin
      if (s2_ff[b] == s3_ff[b]) begin
        nxt_filt[b] = s3_ff[b];
      end
    end
  end

  // Three-stage synchroniser and filter
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_ff   <= tdm_pkg::PINS_RST;
      s2_ff   <= tdm_pkg::PINS_RST;
      s3_ff   <= tdm_pkg::PINS_RST;
      filt_ff <= tdm_pkg::PINS_RST;
    end else if (ce) begin
      s1_ff   <= pins_raw;
      s2_ff   <= s1_ff;
      s3_ff   <= s2_ff;
      filt_ff <= nxt_filt;
    end
  end

  // Control register and effective controls
  logic [tdm_pkg::CTRL_W-1:0] ctrl_ff, nxt_ctrl;
  logic [NUM_CH-1:0]          status_ff, nxt_status;
  logic [NUM_CH-1:0]          mask_ff, nxt_mask;
  logic [NUM_CH-1:0]          drv_on_eff;
  logic                       rise_eff;
  logic                       int_mon_eff;

  always_comb begin
    int_mon_eff = filt_ff.host & ctrl_ff[tdm_pkg::CTRL_INTMON];
    if (filt_ff.host) begin
      rise_eff   = ctrl_ff[tdm_pkg::CTRL_RISE];
      drv_on_eff = ctrl_ff[tdm_pkg::CTRL_TXON_LSB +: NUM_CH];
    end else begin
      rise_eff   = filt_ff.edge_sel;
      drv_on_eff = filt_ff.txon;
    end
  end

  // Edge detection on the filtered transmit clocks
  logic [NUM_CH-1:0] tclk_prev_ff, nxt_tclk_prev;
  logic [NUM_CH-1:0] strobe;

  always_comb begin
    nxt_tclk_prev = filt_ff.tclk;
    if (rise_eff) begin
      strobe = filt_ff.tclk & ~tclk_prev_ff;
    end else begin
      strobe = ~filt_ff.tclk & tclk_prev_ff;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tclk_prev_ff <= '0;
    end else if (ce) begin
      tclk_prev_ff <= nxt_tclk_prev;
    end
  end

  // Channels
  tdm_pkg::tdm_line_s [NUM_CH-1:0] ch_line;
  logic [NUM_CH-1:0]               ch_fault;

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    tdm_pkg::tdm_rail_s rail_i;
    tdm_pkg::tdm_rail_s mon_i;
    assign rail_i = '{pos: filt_ff.pos[i], neg: filt_ff.neg[i]};
    assign mon_i  = '{pos: filt_ff.mpos[i], neg: filt_ff.mneg[i]};
    tdm_chan #(
      .THRESH (THRESH),
      .CNT_W  (tdm_pkg::CNT_W)
    ) u_chan (
      .clk     (clk),
      .reset_n (reset_n),
      .ce      (ce),
      .strobe  (strobe[i]),
      .rail    (rail_i),
      .mon     (mon_i),
      .use_int (int_mon_eff),
      .drv_on  (drv_on_eff[i]),
      .line    (ch_line[i]),
      .fault   (ch_fault[i])
    );
    assign line_out_pos[i] = ch_line[i].pos;
    assign line_out_neg[i] = ch_line[i].neg;
    assign line_out_oe[i]  = ch_line[i].oe;
  end

  assign drive_fault_flag = ch_fault;

  // Write-one-to-clear mask for the status register
  function automatic logic [NUM_CH-1:0] w1c_mask(
    input logic                        wr,
    input logic [tdm_pkg::ADDR_W-1:0]  addr,
    input logic [tdm_pkg::DATA_W-1:0]  wdata
  );
    if (wr && addr == tdm_pkg::ADDR_STATUS) begin
      return wdata[NUM_CH-1:0];
    end
    return '0;
  endfunction : w1c_mask

  // Register file next state
  logic [NUM_CH-1:0]          fault_d_ff, nxt_fault_d;
  logic [NUM_CH-1:0]          fault_rise;
  logic [tdm_pkg::DATA_W-1:0] rdata_ff, nxt_rdata;
  logic                       irq_ff, nxt_irq;
  logic                       sclk_ff, nxt_sclk;

  always_comb begin
    nxt_fault_d = ch_fault;
    fault_rise  = ch_fault & ~fault_d_ff;
    nxt_ctrl    = ctrl_ff;
    nxt_mask    = mask_ff;
    if (reg_wr && reg_addr == tdm_pkg::ADDR_CTRL) begin
      nxt_ctrl = reg_wdata[tdm_pkg::CTRL_W-1:0];
    end
    if (reg_wr && reg_addr == tdm_pkg::ADDR_MASK) begin
      nxt_mask = reg_wdata[NUM_CH-1:0];
    end
    // Set wins over clear
    nxt_status = (status_ff & ~w1c_mask(reg_wr, reg_addr, reg_wdata))
               | fault_rise;
    nxt_irq    = |(nxt_status & nxt_mask);
    nxt_rdata  = '0;
    if (reg_rd) begin
      case (reg_addr)
        tdm_pkg::ADDR_CTRL:   nxt_rdata[tdm_pkg::CTRL_W-1:0] = ctrl_ff;
        tdm_pkg::ADDR_STATUS: nxt_rdata[NUM_CH-1:0] = status_ff;
        tdm_pkg::ADDR_MASK:   nxt_rdata[NUM_CH-1:0] = mask_ff;
        tdm_pkg::ADDR_FAULT:  nxt_rdata[NUM_CH-1:0] = ch_fault;
        default:              nxt_rdata = '0;
      endcase
    end
    nxt_sclk = filt_ff.host & filt_ff.edge_sel;
  end

  // Register file state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_ff    <= tdm_pkg::CTRL_RST;
      mask_ff    <= tdm_pkg::CH_ZERO;
      status_ff  <= tdm_pkg::CH_ZERO;
      fault_d_ff <= tdm_pkg::CH_ZERO;
      rdata_ff   <= '0;
      irq_ff     <= 1'b0;
      sclk_ff    <= 1'b0;
    end else if (ce) begin
      ctrl_ff    <= nxt_ctrl;
      mask_ff    <= nxt_mask;
      status_ff  <= nxt_status;
      fault_d_ff <= nxt_fault_d;
      rdata_ff   <= nxt_rdata;
      irq_ff     <= nxt_irq;
      sclk_ff    <= nxt_sclk;
    end
  end

  assign reg_rdata       = rdata_ff;
  assign irq             = irq_ff;
  assign serial_port_clk = sclk_ff;

  // Checks
  property p_src_hw;
    @(posedge clk) disable iff (!reset_n)
    !filt_ff.host |-> !int_mon_eff;
  endproperty
  a_src_hw: assert property (p_src_hw) else $error("internal tap in hw");

  property p_edge_rise;
    @(posedge clk) disable iff (!reset_n)
    (!filt_ff.host && filt_ff.edge_sel && filt_ff.tclk[0]
      && !tclk_prev_ff[0]) |-> strobe[0];
  endproperty
  a_edge_rise: assert property (p_edge_rise) else $error("rise missed");

  property p_edge_fall;
    @(posedge clk) disable iff (!reset_n)
    (!filt_ff.host && !filt_ff.edge_sel && !filt_ff.tclk[0]
      && tclk_prev_ff[0]) |-> strobe[0];
  endproperty
  a_edge_fall: assert property (p_edge_fall) else $error("fall missed");

  property p_host_sclk;
    @(posedge clk) disable iff (!reset_n)
    (ce && filt_ff.host) |=> (sclk_ff == $past(filt_ff.edge_sel));
  endproperty
  a_host_sclk: assert property (p_host_sclk) else $error("sclk wrong");

  property p_host_noedge;
    @(posedge clk) disable iff (!reset_n)
    filt_ff.host |-> (rise_eff == ctrl_ff[tdm_pkg::CTRL_RISE]);
  endproperty
  a_host_noedge: assert property (p_host_noedge) else $error("pin used");

  property p_irq;
    @(posedge clk) disable iff (!reset_n)
    (ce && |(nxt_status & nxt_mask)) |=> irq_ff;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");

  property p_irq_lo;
    @(posedge clk) disable iff (!reset_n)
    (ce && (nxt_status & nxt_mask) == '0) |=> !irq_ff;
  endproperty
  a_irq_lo: assert property (p_irq_lo) else $error("irq stuck");

  property p_sts_set;
    @(posedge clk) disable iff (!reset_n)
    ce |=> ((status_ff & $past(fault_rise)) == $past(fault_rise));
  endproperty
  a_sts_set: assert property (p_sts_set) else $error("status lost");

  property p_rd_idle;
    @(posedge clk) disable iff (!reset_n)
    (ce && !reg_rd) |=> (rdata_ff == '0);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");

  property p_oe_follow;
    @(posedge clk) disable iff (!reset_n)
    ce |=> (line_out_oe == $past(drv_on_eff));
  endproperty
  a_oe_follow: assert property (p_oe_follow) else $error("oe wrong");

  property p_sclk_hw;
    @(posedge clk) disable iff (!reset_n)
    (ce && !filt_ff.host) |=> !sclk_ff;
  endproperty
  a_sclk_hw: assert property (p_sclk_hw) else $error("sclk in hw");

  property p_int_host;
    @(posedge clk) disable iff (!reset_n)
    (filt_ff.host && ctrl_ff[tdm_pkg::CTRL_INTMON]) |-> int_mon_eff;
  endproperty
  a_int_host: assert property (p_int_host) else $error("tap not chosen");

  c_hw_rise: cover property (@(posedge clk) disable iff (!reset_n)
    !filt_ff.host && filt_ff.edge_sel && strobe[0]);
  c_host_int: cover property (@(posedge clk) disable iff (!reset_n)
    int_mon_eff && ch_fault[0]);
  c_irq: cover property (@(posedge clk) disable iff (!reset_n)
    !irq_ff ##1 irq_ff);

endmodule : tdm_top

// >>> tdm_term_model.sv
`timescale 1ns/1ps
module tdm_term_model (
  // Bench control
  input  wire logic [tdm_pkg::NUM_CH-1:0] mark_en,
  input  wire logic [tdm_pkg::NUM_CH-1:0] mark_neg,
  input  wire logic                       cut,
  // Line side of the block
  input  wire logic [tdm_pkg::NUM_CH-1:0] line_pos,
  input  wire logic [tdm_pkg::NUM_CH-1:0] line_neg,
  input  wire logic [tdm_pkg::NUM_CH-1:0] line_oe,
  // Terminal and monitor pins
  output logic      [tdm_pkg::NUM_CH-1:0] tclk,
  output logic      [tdm_pkg::NUM_CH-1:0] pos,
  output logic      [tdm_pkg::NUM_CH-1:0] neg,
  output logic      [tdm_pkg::NUM_CH-1:0] mpos,
  output logic      [tdm_pkg::NUM_CH-1:0] mneg
);
  logic [tdm_pkg::NUM_CH-1:0] last_pos = '0;
  logic [tdm_pkg::NUM_CH-1:0] last_neg = '0;

  // Free running transmit clock, phase unrelated to clk
  initial begin
    tclk = '0;
    #3.3;
    forever #32 tclk = ~tclk;
  end

  // Rail pulse centred on the rising clock edge only
  initial begin
    pos = '0;
    neg = '0;
    forever begin
      @(negedge tclk[0]);
      #16;
      pos = mark_en & ~mark_neg;
      neg = mark_en & mark_neg;
      @(posedge tclk[0]);
      #16;
      pos = '0;
      neg = '0;
    end
  end

  // Last level seen while the driver was on
  always @(line_pos or line_neg or line_oe) begin
    for (int i = 0; i < tdm_pkg::NUM_CH; i++) begin
      if (line_oe[i]) begin
        last_pos[i] = line_pos[i];
        last_neg[i] = line_neg[i];
      end
    end
  end

  // Series resistor loop; a released line shows the inverse level
  always_comb begin
    for (int i = 0; i < tdm_pkg::NUM_CH; i++) begin
      if (cut) begin
        mpos[i] = ~last_pos[i]; // Open path, both float together
        mneg[i] = ~last_pos[i];
      end else if (line_oe[i]) begin
        mpos[i] = line_pos[i];
        mneg[i] = line_neg[i];
      end else begin
        mpos[i] = ~last_pos[i];
        mneg[i] = ~last_neg[i];
      end
    end
  end
endmodule : tdm_term_model

// >>> tdm_top_tb.sv
`timescale 1ns/1ps
`define CHK(nm, gt, ex) begin \
  cmp_count++; \
  if ((gt) !== (ex)) begin \
    n_errors++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, gt); \
  end \
end
module tdm_top_tb;
  localparam int THRESH = 4;
  localparam int BIT    = 8;
  logic        clk, reset_n, ce, host_mode, edge_sel, cut;
  logic        reg_wr, reg_rd, irq, spclk;
  logic [2:0]  drv_on, mark_en, mark_neg, tclk, tpos, tneg, mpos, mneg;
  logic [2:0]  lpos, lneg, loe, fault;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  int          n_errors, cmp_count, n;

  // Clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  tdm_top #(.NUM_CH(tdm_pkg::NUM_CH), .THRESH(THRESH)) tdm_top_i (
    .clk(clk), .reset_n(reset_n), .ce(ce), .host_mode(host_mode),
    .tx_clock_edge_select(edge_sel), .tx_line_clock(tclk),
    .tx_pos_rail(tpos), .tx_neg_rail(tneg), .tx_driver_on(drv_on),
    .monitor_pos_in(mpos), .monitor_neg_in(mneg), .line_out_pos(lpos),
    .line_out_neg(lneg), .line_out_oe(loe), .drive_fault_flag(fault),
    .serial_port_clk(spclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

  tdm_term_model tdm_term_model_i (
    .mark_en(mark_en), .mark_neg(mark_neg), .cut(cut), .line_pos(lpos),
    .line_neg(lneg), .line_oe(loe), .tclk(tclk), .pos(tpos), .neg(tneg),
    .mpos(mpos), .mneg(mneg));

  // Verdict and end of run
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  // One write strobe cycle
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // One read strobe cycle, data taken in the next cycle
  task automatic rd(input logic [3:0] a, input logic [31:0] ex,
                    input string nm);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    `CHK(nm, reg_rdata, ex)
  endtask : rd

  // Bounded wait for one fault flag
  task automatic wait_flag(input int ch, input logic v, output int k);
    k = 0;
    while (fault[ch] !== v) begin
      @(posedge clk);
      #1;
      k++;
      if (k > 40 * BIT) begin
        n_errors++;
        $display("[FAIL] fault flag wait timed out");
        wrap_up();
      end
    end
  endtask : wait_flag

  // Enough bit periods for line and monitor to settle
  task automatic settle();
    repeat ((THRESH + 4) * BIT) @(posedge clk);
    #1;
  endtask : settle

  // Main sequence
  initial begin
    reset_n = 1'b0; host_mode = 1'b0; edge_sel = 1'b1; cut = 1'b0;
    reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0; reg_wdata = 32'h0;
    // Line pins up before release so ch0 and ch1 never run idle
    drv_on = 3'h7; mark_en = 3'h3; mark_neg = 3'h2; ce = 1'b1;
    n_errors = 0; cmp_count = 0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    #1;
    `CHK("oe after reset", loe, 3'h0)
    rd(tdm_pkg::ADDR_CTRL, 32'h0, "ctrl reset");
    rd(tdm_pkg::ADDR_STATUS, 32'h0, "status reset");
    rd(tdm_pkg::ADDR_MASK, 32'h0, "mask reset");
    rd(tdm_pkg::ADDR_FAULT, 32'h0, "fault reset");
    wr(4'h2, 32'hffffffff);
    rd(4'h2, 32'h0, "unmapped read");
    rd(tdm_pkg::ADDR_CTRL, 32'h0, "ctrl after unmapped write");
    // Hardware mode, rising edge, ch0 positive, ch1 negative, ch2 idle
    @(posedge clk);
    drv_on <= 3'h7; mark_en <= 3'h3; mark_neg <= 3'h2;
    settle();
    `CHK("oe on", loe, 3'h7)
    `CHK("pos levels", lpos, 3'h1)
    `CHK("neg levels", lneg, 3'h2)
    `CHK("fault idle ch2", fault, 3'h4)
    rd(tdm_pkg::ADDR_STATUS, 32'h4, "status sticky");
    `CHK("irq masked", irq, 1'b0)
    wr(tdm_pkg::ADDR_MASK, 32'h4);
    repeat (2) @(posedge clk);
    #1;
    `CHK("irq unmasked", irq, 1'b1)
    wr(tdm_pkg::ADDR_STATUS, 32'h4);
    rd(tdm_pkg::ADDR_STATUS, 32'h0, "status cleared");
    `CHK("irq after clear", irq, 1'b0)
    rd(tdm_pkg::ADDR_FAULT, 32'h4, "fault register");
    // Bounded idle count before the flag rises, then clears on a pulse
    for (n = 0; n < 2 * BIT && !tclk[0]; n++) begin
      @(posedge clk);
    end
    `CHK("tclk high", tclk[0], 1'b1)
    @(posedge clk);
    mark_en <= 3'h2;
    // One bit to reach the line, one bit of monitor echo, then idle bits
    wait_flag(0, 1'b1, n);
    `CHK("idle count low", n >= (THRESH+1)*BIT+4, 1'b1)
    `CHK("idle count high", n <= (THRESH+2)*BIT+4, 1'b1)
    @(posedge clk);
    mark_en <= 3'h3;
    wait_flag(0, 1'b0, n);
    `CHK("clear on pulse", n <= 3 * BIT, 1'b1)
    // Falling edge misses the rail pulses
    @(posedge clk);
    edge_sel <= 1'b0;
    settle();
    `CHK("falling pos", lpos, 3'h0)
    `CHK("falling neg", lneg, 3'h0)
    `CHK("falling fault", fault, 3'h7)
    `CHK("no serial clock in hw", spclk, 1'b0)
    // Host mode: edge and driver-on from control, pin is serial clock
    @(posedge clk);
    host_mode <= 1'b1; drv_on <= 3'h2;
    wr(tdm_pkg::ADDR_CTRL, 32'h15);
    settle();
    rd(tdm_pkg::ADDR_CTRL, 32'h15, "ctrl readback");
    `CHK("host oe", loe, 3'h5)
    `CHK("host pos", lpos, 3'h1)
    `CHK("host neg off ch", lneg, 3'h0)
    `CHK("serial clock low", spclk, 1'b0)
    @(posedge clk);
    edge_sel <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    `CHK("serial clock high", spclk, 1'b1)
    // Monitor source selection
    @(posedge clk);
    cut <= 1'b1;
    settle();
    `CHK("external path cut", fault[0], 1'b1)
    wr(tdm_pkg::ADDR_CTRL, 32'h1d);
    settle();
    `CHK("internal tap", fault[0], 1'b0)
    @(posedge clk);
    host_mode <= 1'b0; drv_on <= 3'h7;
    settle();
    `CHK("hw ignores internal", fault[0], 1'b1)
    // Clock enable low drops a register write
    @(posedge clk);
    ce <= 1'b0;
    wr(tdm_pkg::ADDR_CTRL, 32'h0);
    ce <= 1'b1;
    rd(tdm_pkg::ADDR_CTRL, 32'h1d, "ctrl frozen");
    wrap_up();
  end
endmodule : tdm_top_tb
